// ---- hdl/dpot_device.sv ----
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module dpot_device
    import dpot_pkg::*;
#(
    parameter int NVW_CYCLES = NVW_CYC
) (
    input logic CLOCK,
    input logic RST,
    input logic WRITE_PROT_N,
    input logic [3:0] SLAVE_ADDR_PINS,
    output logic [255:0] TAPS0,
    output logic [255:0] TAPS1,
    output logic NV_BUSY,
    dpot_link.dev LINK
);
    typedef enum logic [2:0] {
        D_IDLE, D_ADDR, D_INSTR, D_RX, D_TX, D_STEP
    } dstate_e;

    // [0] first stage, [1] synced level, [2] previous synced level
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] wp_s;
    logic [3:0] addr_s0;
    logic [3:0] addr_s1;

    dstate_e state_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [7:0] ins_r;
    logic oe_r;
    logic step_dir_r;

    logic [7:0] wiper_r [2];
    logic [7:0] stored_r [2][4];
    logic [255:0] tap_r [2];
    logic pu_recall_r;
    logic [1:0] rcl_pots_r;
    logic [1:0] rcl_idx_r;
    logic [7:0] rcl_cnt_r;

    logic nv_pend_r;
    logic [1:0] nv_pots_r;
    logic [1:0] nv_idx_r;
    logic [7:0] nv_val_r [2];
    logic [31:0] busy_cnt_r;
    logic busy_r;

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic byte_done;
    logic ins_go;
    logic rx_go;
    logic step_go;
    logic [3:0] op_w;
    logic pot_w;
    logic [1:0] ptr_w;

    // pins from the far side pass two flops before any use
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            wp_s <= 2'h0;
            addr_s0 <= 4'h0;
            addr_s1 <= 4'h0;
        end else begin
            scl_s <= {scl_s[1:0], LINK.scl};
            sda_s <= {sda_s[1:0], LINK.sda};
            wp_s <= {wp_s[0], WRITE_PROT_N};
            addr_s0 <= SLAVE_ADDR_PINS;
            addr_s1 <= addr_s0;
        end
    end

    // link events, all seen on synced levels only
    assign scl_rise = scl_s[1] & ~scl_s[2];
    assign scl_fall = ~scl_s[1] & scl_s[2];
    assign start_ev = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    assign stop_ev = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
    assign byte_done = scl_fall && cnt_r == 4'd7;
    assign op_w = shift_r[INS_OP_LSB+:4];
    assign pot_w = shift_r[INS_POT_BIT];
    assign ptr_w = shift_r[INS_PTR_LSB+:2];
    assign ins_go = byte_done && state_r == D_INSTR && instr_ok(shift_r);
    assign rx_go = byte_done && state_r == D_RX;
    // a step lands on the falling edge so a stop never counts as a step
    assign step_go = scl_fall && state_r == D_STEP && cnt_r == 4'd0;

    // serial byte engine: shift on rise, acknowledge and drive on fall
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_r <= D_IDLE;
            cnt_r <= 4'd0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            ins_r <= 8'h00;
            oe_r <= 1'b0;
            step_dir_r <= 1'b0;
        end else if (start_ev) begin
            state_r <= D_ADDR;
            cnt_r <= 4'd8; // the fall that closes a start is not a bit
            oe_r <= 1'b0;
        end else if (stop_ev) begin
            state_r <= D_IDLE;
            cnt_r <= 4'd0;
            oe_r <= 1'b0;
        end else begin
            if (scl_rise && cnt_r < 4'd8)
                shift_r <= {shift_r[6:0], sda_s[1]};
            if (scl_rise)
                step_dir_r <= sda_s[1];
            if (scl_fall && (cnt_r == 4'd8 ||
                    (state_r != D_IDLE && state_r != D_STEP))) begin
                if (cnt_r == 4'd8) begin
                    cnt_r <= 4'd0;
                    oe_r <= (state_r == D_TX) & ~tx_r[7];
                    if (state_r == D_TX)
                        tx_r <= {tx_r[6:0], 1'b0};
                end else if (cnt_r == 4'd7) begin
                    cnt_r <= 4'd8;
                    oe_r <= 1'b0;
                    state_r <= D_IDLE;
                    case (state_r)
                        D_ADDR: begin
                            // silent while a stored write runs
                            if (shift_r == {DEV_TYPE_ID, addr_s1} &&
                                    !busy_r) begin
                                oe_r <= 1'b1;
                                state_r <= D_INSTR;
                            end
                        end
                        D_INSTR: begin
                            if (instr_ok(shift_r)) begin
                                oe_r <= 1'b1;
                                ins_r <= shift_r;
                                if (op_w == OP_STEP)
                                    state_r <= D_STEP;
                                else if (is_read(op_w))
                                    state_r <= D_TX;
                                else if (has_data(op_w))
                                    state_r <= D_RX;
                                else
                                    state_r <= D_IDLE;
                                if (op_w == OP_RD_WIPER)
                                    tx_r <= wiper_r[pot_w];
                                else
                                    tx_r <= stored_r[pot_w][ptr_w];
                            end
                        end
                        D_RX: oe_r <= 1'b1;
                        default: oe_r <= 1'b0; // master leaves the read unacknowledged
                    endcase
                end else begin
                    cnt_r <= cnt_r + 4'd1;
                    if (state_r == D_TX) begin
                        oe_r <= ~tx_r[7];
                        tx_r <= {tx_r[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // wiper: power-up recall, delayed transfers, direct load, stepping
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            wiper_r <= '{default: 8'h00};
            pu_recall_r <= 1'b1;
            rcl_pots_r <= 2'h0;
            rcl_idx_r <= 2'h0;
            rcl_cnt_r <= 8'd0;
        end else begin
            pu_recall_r <= 1'b0;
            for (int p = 0; p < 2; p++) begin
                if (pu_recall_r)
                    wiper_r[p] <= stored_r[p][0];
                else if (rcl_cnt_r == 8'd1 && rcl_pots_r[p])
                    wiper_r[p] <= stored_r[p][rcl_idx_r];
            end
            if (rcl_cnt_r != 8'd0)
                rcl_cnt_r <= rcl_cnt_r - 8'd1;
            if (ins_go && op_w == OP_XFR_TO_WIPER) begin
                rcl_pots_r <= pot_w ? 2'h2 : 2'h1;
                rcl_idx_r <= ptr_w;
                rcl_cnt_r <= 8'(WRL_CYC);
            end else if (ins_go && op_w == OP_GXFR_TO_WIPER) begin
                rcl_pots_r <= 2'h3;
                rcl_idx_r <= ptr_w;
                rcl_cnt_r <= 8'(WRL_CYC);
            end
            if (rx_go && ins_r[INS_OP_LSB+:4] == OP_WR_WIPER)
                wiper_r[ins_r[INS_POT_BIT]] <= shift_r;
            // saturate rather than wrap at either end
            if (step_go) begin
                if (step_dir_r && wiper_r[ins_r[INS_POT_BIT]] != 8'hFF)
                    wiper_r[ins_r[INS_POT_BIT]] <=
                        wiper_r[ins_r[INS_POT_BIT]] + 8'h01;
                else if (!step_dir_r &&
                        wiper_r[ins_r[INS_POT_BIT]] != 8'h00)
                    wiper_r[ins_r[INS_POT_BIT]] <=
                        wiper_r[ins_r[INS_POT_BIT]] - 8'h01;
            end
        end
    end

    // stored writes wait for the stop, then run as one timed cycle
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            stored_r <= '{default: '{default: STORED_RESET}};
            nv_pend_r <= 1'b0;
            nv_pots_r <= 2'h0;
            nv_idx_r <= 2'h0;
            nv_val_r <= '{default: 8'h00};
            busy_cnt_r <= 32'd0;
            busy_r <= 1'b0;
        end else begin
            if (busy_cnt_r != 32'd0)
                busy_cnt_r <= busy_cnt_r - 32'd1;
            busy_r <= busy_cnt_r > 32'd1 ||
                      (stop_ev && nv_pend_r && wp_s[1]);
            if (start_ev) begin
                nv_pend_r <= 1'b0;
            end else if (stop_ev) begin
                nv_pend_r <= 1'b0;
                // protected writes are dropped without a busy period
                if (nv_pend_r && wp_s[1]) begin
                    busy_cnt_r <= 32'(NVW_CYCLES);
                    for (int p = 0; p < 2; p++)
                        if (nv_pots_r[p])
                            stored_r[p][nv_idx_r] <= nv_val_r[p];
                end
            end else if (ins_go && (op_w == OP_XFR_TO_STORED ||
                    op_w == OP_GXFR_TO_STORED)) begin
                nv_pend_r <= 1'b1;
                nv_idx_r <= ptr_w;
                nv_val_r <= wiper_r;
                if (op_w == OP_GXFR_TO_STORED)
                    nv_pots_r <= 2'h3;
                else
                    nv_pots_r <= pot_w ? 2'h2 : 2'h1;
            end else if (rx_go &&
                    ins_r[INS_OP_LSB+:4] == OP_WR_STORED) begin
                nv_pend_r <= 1'b1;
                nv_idx_r <= ins_r[INS_PTR_LSB+:2];
                nv_pots_r <= ins_r[INS_POT_BIT] ? 2'h2 : 2'h1;
                nv_val_r <= '{default: shift_r};
            end
        end
    end

    // one closed tap switch per pot, none while reset is held
    for (genvar p = 0; p < 2; p++) begin : g_tap
        always_ff @(posedge CLOCK) begin
            if (RST)
                tap_r[p] <= 256'h0;
            else
                tap_r[p] <= 256'h1 << wiper_r[p];
        end
    end

    assign TAPS0 = tap_r[0];
    assign TAPS1 = tap_r[1];
    assign NV_BUSY = busy_r;
    assign LINK.dev_sda_o = 1'b0;
    assign LINK.dev_sda_oe = oe_r;
endmodule : dpot_device

// ---- hdl/dpot_host.sv ----
`timescale 1ns/1ps
module dpot_host
    import dpot_pkg::*;
(
    input logic CLOCK,
    input logic RST,
    input logic [1:0] ADDR,
    input logic [15:0] WDATA,
    input logic WR,
    input logic RD,
    output logic [15:0] RDATA,
    output logic BUSY,
    dpot_link.host LINK
);
    typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} hstate_e;

    logic [11:0] cmd_r;
    logic [7:0] data_r;
    logic dir_r;
    logic [15:0] rdata_r;
    hstate_e st_r;
    logic [1:0] ph_r;
    logic [3:0] qcnt_r;
    logic scl_r;
    logic oe_r;
    logic [1:0] byte_r;
    logic [3:0] bit_r;
    logic step_r;
    logic [7:0] left_r;
    logic busy_r;
    logic nack_r;
    logic [7:0] rx_r;
    logic [1:0] sda_s;

    logic go;
    logic tick;
    logic [3:0] op;
    logic reading;
    logic [7:0] cur;
    logic low_w;

    assign go = WR && ADDR == REG_CTRL && WDATA[CTRL_GO_BIT] &&
                st_r == H_IDLE;
    assign tick = qcnt_r == 4'(QTR_CYC - 1);
    assign op = cmd_r[INS_OP_LSB+:4];
    assign reading = byte_r == 2'd2 && is_read(op);

    // byte on the wire and the level to put out for the current bit
    always_comb begin
        case (byte_r)
            2'd0: cur = {DEV_TYPE_ID, cmd_r[CMD_ADDR_LSB+:4]};
            2'd1: cur = cmd_r[7:0];
            default: cur = data_r;
        endcase
        if (step_r)
            low_w = ~dir_r;
        else if (bit_r < 4'd8 && !reading)
            low_w = ~cur[3'(4'd7 - bit_r)];
        else
            low_w = 1'b0; // release for acknowledge or read data
    end

    // data line from the far side, two flops before use
    always_ff @(posedge CLOCK) begin
        if (RST)
            sda_s <= 2'h3;
        else
            sda_s <= {sda_s[0], LINK.sda};
    end

    // software registers; read data stands only in the following cycle
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cmd_r <= 12'h000;
            data_r <= 8'h00;
            dir_r <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            if (WR && ADDR == REG_CMD)
                cmd_r <= WDATA[11:0];
            if (WR && ADDR == REG_DATA)
                data_r <= WDATA[7:0];
            if (WR && ADDR == REG_CTRL)
                dir_r <= WDATA[CTRL_DIR_BIT];
            if (!RD)
                rdata_r <= 16'h0000;
            else
                case (ADDR)
                    REG_CMD: rdata_r <= {4'h0, cmd_r};
                    REG_DATA: rdata_r <= {8'h00, data_r};
                    REG_CTRL: rdata_r <= {left_r, 6'h00, dir_r, 1'b0};
                    default: rdata_r <= {6'h00, nack_r, busy_r, rx_r};
                endcase
        end
    end

    // sequencer: four quarter phases per serial bit
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_r <= H_IDLE;
            ph_r <= 2'd0;
            qcnt_r <= 4'h0;
            scl_r <= 1'b1;
            oe_r <= 1'b0;
            byte_r <= 2'd0;
            bit_r <= 4'd0;
            step_r <= 1'b0;
            left_r <= 8'h00;
            busy_r <= 1'b0;
            nack_r <= 1'b0;
            rx_r <= 8'h00;
        end else if (go) begin
            st_r <= H_START;
            ph_r <= 2'd0;
            qcnt_r <= 4'h0;
            byte_r <= 2'd0;
            bit_r <= 4'd0;
            step_r <= 1'b0;
            left_r <= WDATA[CTRL_STEPS_LSB+:8];
            busy_r <= 1'b1;
            nack_r <= 1'b0;
        end else if (st_r != H_IDLE) begin
            qcnt_r <= tick ? 4'h0 : qcnt_r + 4'h1;
            if (tick) begin
                ph_r <= ph_r + 2'd1;
                case (st_r)
                    H_START: begin
                        if (ph_r == 2'd0)
                            oe_r <= 1'b1;
                        else if (ph_r == 2'd3) begin
                            scl_r <= 1'b0;
                            st_r <= H_BITS;
                        end
                    end
                    H_BITS: begin
                        if (ph_r == 2'd0)
                            oe_r <= low_w;
                        else if (ph_r == 2'd1)
                            scl_r <= 1'b1;
                        else if (ph_r == 2'd3) begin
                            scl_r <= 1'b0;
                            if (step_r) begin
                                left_r <= left_r - 8'h01;
                                if (left_r == 8'h01)
                                    st_r <= H_STOP;
                            end else if (bit_r != 4'd8) begin
                                bit_r <= bit_r + 4'd1;
                                if (reading)
                                    rx_r <= {rx_r[6:0], sda_s[1]};
                            end else begin
                                bit_r <= 4'd0;
                                if (!reading && sda_s[1]) begin
                                    nack_r <= 1'b1;
                                    st_r <= H_STOP;
                                end else if (byte_r ==
                                        (has_data(op) ? 2'd2 : 2'd1)) begin
                                    if (op == OP_STEP && left_r != 8'h00)
                                        step_r <= 1'b1;
                                    else
                                        st_r <= H_STOP;
                                end else
                                    byte_r <= byte_r + 2'd1;
                            end
                        end
                    end
                    H_STOP: begin
                        if (ph_r == 2'd0)
                            oe_r <= 1'b1;
                        else if (ph_r == 2'd1)
                            scl_r <= 1'b1;
                        else if (ph_r == 2'd2)
                            oe_r <= 1'b0;
                        else begin
                            st_r <= H_IDLE;
                            busy_r <= 1'b0;
                        end
                    end
                    default: st_r <= H_IDLE;
                endcase
            end
        end
    end

    assign RDATA = rdata_r;
    assign BUSY = busy_r;
    assign LINK.scl = scl_r;
    assign LINK.host_sda_o = 1'b0;
    assign LINK.host_sda_oe = oe_r;
endmodule : dpot_host

// ---- hdl/dpot_link.sv ----
`timescale 1ns/1ps
// two-wire link: the host makes the serial clock, data is open drain
interface dpot_link;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // wired-and with a pull-up: any enabled low driver wins
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport dev (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe
    );
    modport host (
        output scl,
        output host_sda_o,
        output host_sda_oe,
        input sda
    );
endinterface : dpot_link

// ---- hdl/dpot_pkg.sv ----
package dpot_pkg;
    // system clock
    localparam int CLK_PERIOD_NS = 50;
    // longest nonvolatile write, rounded down to whole cycles
    localparam int NVW_TIME_NS = 10_000_000;
    localparam int NVW_CYC = NVW_TIME_NS / CLK_PERIOD_NS;
    // wiper recall delay after a stored-to-wiper transfer
    localparam int WRL_TIME_NS = 1000;
    localparam int WRL_CYC = (WRL_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                             WRL_TIME_NS / CLK_PERIOD_NS;
    // device type nibble of the identification byte; value is arbitrary
    localparam logic [3:0] DEV_TYPE_ID = 4'hA;
    // stored register contents after reset
    localparam logic [7:0] STORED_RESET = 8'h80;
    // host serial clock quarter period in system cycles
    localparam int QTR_CYC = 3;

    // instruction opcodes
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_STORED = 4'hB;
    localparam logic [3:0] OP_WR_STORED = 4'hC;
    localparam logic [3:0] OP_XFR_TO_WIPER = 4'hD;
    localparam logic [3:0] OP_XFR_TO_STORED = 4'hE;
    localparam logic [3:0] OP_GXFR_TO_WIPER = 4'h1;
    localparam logic [3:0] OP_GXFR_TO_STORED = 4'h8;
    localparam logic [3:0] OP_STEP = 4'h2;
    // instruction byte fields
    localparam int INS_OP_LSB = 4;
    localparam int INS_PTR_LSB = 2;
    localparam int INS_RSV_BIT = 1;
    localparam int INS_POT_BIT = 0;

    // host register map
    localparam logic [1:0] REG_CMD = 2'h0;
    localparam logic [1:0] REG_DATA = 2'h1;
    localparam logic [1:0] REG_CTRL = 2'h2;
    localparam logic [1:0] REG_STAT = 2'h3;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_DIR_BIT = 1;
    localparam int CTRL_STEPS_LSB = 8;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_NACK_BIT = 9;

    // opcodes followed by one data byte
    function automatic logic has_data(input logic [3:0] op);
        return op inside {OP_RD_WIPER, OP_WR_WIPER, OP_RD_STORED,
                          OP_WR_STORED};
    endfunction : has_data

    // opcodes whose data byte the device drives
    function automatic logic is_read(input logic [3:0] op);
        return op == OP_RD_WIPER || op == OP_RD_STORED;
    endfunction : is_read

    // defined opcode with its fixed bits at their required values
    function automatic logic instr_ok(input logic [7:0] ins);
        logic [3:0] op;
        logic ptr0;
        logic pot0;
        op = ins[INS_OP_LSB+:4];
        ptr0 = ins[INS_PTR_LSB+:2] == 2'h0;
        pot0 = !ins[INS_POT_BIT];
        if (ins[INS_RSV_BIT])
            return 1'b0;
        case (op)
            OP_RD_WIPER, OP_WR_WIPER, OP_STEP: return ptr0;
            OP_RD_STORED, OP_WR_STORED: return 1'b1;
            OP_XFR_TO_WIPER, OP_XFR_TO_STORED: return 1'b1;
            OP_GXFR_TO_WIPER, OP_GXFR_TO_STORED: return pot0;
            default: return 1'b0;
        endcase
    endfunction : instr_ok
endpackage : dpot_pkg

// ---- verif/dpot_link_assertions.sv ----
`timescale 1ns/1ps
module dpot_link_assertions (
    input logic CLOCK,
    input logic RST,
    input logic scl,
    input logic host_sda_o,
    input logic host_sda_oe,
    input logic dev_sda_o,
    input logic dev_sda_oe
);
    // single domain, so clocking and reset are given once
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    property p_host_od; host_sda_oe |-> !host_sda_o; endproperty
    property p_dev_od; dev_sda_oe |-> !dev_sda_o; endproperty
    property p_rst_idle;
        $fell(RST) |-> scl && !host_sda_oe && !dev_sda_oe;
    endproperty
    // the slave may only move data while the clock is low
    property p_dev_low; $changed(dev_sda_oe) |-> !scl && !$past(scl);
    endproperty
    property p_dev_release; $rose(dev_sda_oe) |-> ##[1:130] !dev_sda_oe;
    endproperty
    property p_scl_high; $rose(scl) |-> scl [*6]; endproperty
    property p_scl_low; $fell(scl) |-> !scl [*3]; endproperty
    // contention would corrupt a slave-driven bit
    property p_no_fight; scl && dev_sda_oe |-> !host_sda_oe; endproperty
    a_host_od: assert property (p_host_od) else $error("host drives high");
    a_dev_od: assert property (p_dev_od) else $error("dev drives high");
    a_rst_idle: assert property (p_rst_idle) else $error("bus not idle");
    a_dev_low: assert property (p_dev_low) else $error("sda moved");
    a_dev_release: assert property (p_dev_release)
        else $error("slave holds sda");
    a_scl_high: assert property (p_scl_high) else $error("short high");
    a_scl_low: assert property (p_scl_low) else $error("short low");
    a_no_fight: assert property (p_no_fight) else $error("bus fight");
endmodule : dpot_link_assertions

// ---- verif/dual_pot_command_decoder_tb.sv ----
`timescale 1ns/1ps
module dual_pot_command_decoder_tb;
    import dpot_pkg::*;
    logic CLOCK = 1'b0, RST = 1'b1, wr = 1'b0, rd = 1'b0, wp_n = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic busy, nv_busy;
    logic [255:0] taps0, taps1;
    int bad_count = 0, checks_done = 0;
    dpot_link link ();
    // short write cycle, still long enough to poll the address during it
    dpot_device #(.NVW_CYCLES(300)) dpot_device_inst (.CLOCK(CLOCK),
        .RST(RST), .WRITE_PROT_N(wp_n), .SLAVE_ADDR_PINS(4'h5),
        .TAPS0(taps0), .TAPS1(taps1), .NV_BUSY(nv_busy), .LINK(link));
    dpot_host dpot_host_inst (.CLOCK(CLOCK), .RST(RST), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BUSY(busy),
        .LINK(link));
    dpot_link_assertions chk_inst (.CLOCK(CLOCK), .RST(RST),
        .scl(link.scl), .host_sda_o(link.host_sda_o),
        .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
        .dev_sda_oe(link.dev_sda_oe));
    // 50 ns system clock
    initial begin
        forever #25 CLOCK = ~CLOCK;
    end
    task automatic finish_test;
        if (bad_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [255:0] hot(input logic [7:0] v);
        return 256'h1 << v;
    endfunction : hot
    function automatic logic [7:0] ib(input logic [3:0] op,
                                      input logic [1:0] p, input logic pot);
        return {op, p, 1'b0, pot};
    endfunction : ib
    task automatic wreg(input logic [1:0] a, input logic [15:0] d);
        @(posedge CLOCK);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge CLOCK);
        wr <= 1'b0;
    endtask : wreg
    // read data stand only in the cycle after the strobe
    task automatic rstat(output logic [15:0] v);
        @(posedge CLOCK);
        addr <= REG_STAT;
        rd <= 1'b1;
        @(posedge CLOCK);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rstat
    // one link sequence, returns once the host has sent its stop
    task automatic launch(input logic [7:0] ins, input logic [15:0] d,
                          input logic [15:0] ctl);
        int n;
        wreg(REG_CMD, {8'h05, ins});
        wreg(REG_DATA, d);
        wreg(REG_CTRL, ctl | 16'h0001);
        repeat (2) @(posedge CLOCK);
        for (n = 0; busy && n < 20000; n++) @(posedge CLOCK);
        if (busy !== 1'b0) begin
            bad_count++;
            finish_test();
        end
    endtask : launch
    // whole sequence, then wait out recall delay and any write cycle
    task automatic run(input logic [7:0] ins, input logic [15:0] d,
                       input logic [15:0] ctl);
        int n;
        launch(ins, d, ctl);
        repeat (30) @(posedge CLOCK);
        for (n = 0; nv_busy && n < 500; n++) @(posedge CLOCK);
        if (busy !== 1'b0 || nv_busy !== 1'b0) begin
            bad_count++;
            finish_test();
        end
    endtask : run
    task automatic rdchk(input logic [7:0] ins, input logic [7:0] exp);
        logic [15:0] v;
        run(ins, 16'h0000, 16'h0000);
        rstat(v);
        chk(v[7:0], exp);
    endtask : rdchk
    initial begin
        logic [15:0] s;
        int n;
        repeat (4) @(posedge CLOCK);
        RST <= 1'b0;
        repeat (6) @(posedge CLOCK);
        chk(taps0, hot(8'h80));
        chk(taps1, hot(8'h80));
        run(ib(OP_WR_WIPER, 2'h0, 1'h1), 16'h0055, 16'h0000);
        chk(taps1, hot(8'h55));
        rdchk(ib(OP_RD_WIPER, 2'h0, 1'h1), 8'h55);
        run(ib(OP_WR_STORED, 2'h2, 1'h0), 16'h003C, 16'h0000);
        rdchk(ib(OP_RD_STORED, 2'h2, 1'h0), 8'h3C);
        rdchk(ib(OP_RD_STORED, 2'h1, 1'h0), 8'h80);
        run(ib(OP_XFR_TO_WIPER, 2'h2, 1'h0), 16'h0000, 16'h0000);
        chk(taps0, hot(8'h3C));
        run(ib(OP_XFR_TO_STORED, 2'h3, 1'h1), 16'h0000, 16'h0000);
        rdchk(ib(OP_RD_STORED, 2'h3, 1'h1), 8'h55);
        run(ib(OP_GXFR_TO_STORED, 2'h1, 1'h0), 16'h0000, 16'h0000);
        rdchk(ib(OP_RD_STORED, 2'h1, 1'h0), 8'h3C);
        run(ib(OP_GXFR_TO_WIPER, 2'h0, 1'h0), 16'h0000, 16'h0000);
        chk(taps0, hot(8'h80));
        chk(taps1, hot(8'h80));
        run(ib(OP_STEP, 2'h0, 1'h1), 16'h0000, 16'h0302);
        chk(taps1, hot(8'h83));
        run(ib(OP_STEP, 2'h0, 1'h1), 16'h0000, 16'h0500);
        chk(taps1, hot(8'h7E));
        run(ib(OP_WR_WIPER, 2'h0, 1'h0), 16'h00FE, 16'h0000);
        run(ib(OP_STEP, 2'h0, 1'h0), 16'h0000, 16'h0302);
        chk(taps0, hot(8'hFF));
        wp_n <= 1'b0;
        run(ib(OP_WR_STORED, 2'h2, 1'h0), 16'h0011, 16'h0000);
        wp_n <= 1'b1;
        rdchk(ib(OP_RD_STORED, 2'h2, 1'h0), 8'h3C);
        run(8'hA2, 16'h0011, 16'h0000);
        rstat(s);
        chk(s[STAT_NACK_BIT], 1'b1);
        chk(taps0, hot(8'hFF));
        // address polled while the stored write still runs gets no ack
        launch(ib(OP_WR_STORED, 2'h0, 1'h1), 16'h0042, 16'h0000);
        launch(ib(OP_RD_STORED, 2'h0, 1'h1), 16'h0000, 16'h0000);
        rstat(s);
        chk(s[STAT_NACK_BIT], 1'b1);
        chk(nv_busy, 1'b1);
        for (n = 0; nv_busy && n < 500; n++) @(posedge CLOCK);
        rdchk(ib(OP_RD_STORED, 2'h0, 1'h1), 8'h42);
        finish_test();
    end
endmodule : dual_pot_command_decoder_tb
